/* rtl/isf_pkg.sv */
package isf_pkg;
   // Register byte offsets
   localparam logic [7:0] ISF_OFF_CTRL = 8'h00;
   localparam logic [7:0] ISF_OFF_DATA = 8'h04;
   localparam logic [7:0] ISF_OFF_TRIG = 8'h08;
   localparam logic [7:0] ISF_OFF_STAT = 8'h10;
   // Control register fields
   localparam int ISF_CTL_EN = 0;
   localparam int ISF_CTL_SLWT = 1;
   localparam int ISF_CTL_CONT = 2;
   localparam int ISF_CTL_ADDR_LSB = 8;
   // Trigger register fields
   localparam int ISF_TRG_LRET = 0;
   localparam int ISF_TRG_WRET = 1;
   localparam int ISF_TRG_STT = 2;
   localparam int ISF_TRG_SPT = 3;
   // Status register fields
   localparam int ISF_ST_MS = 15;
   localparam int ISF_ST_DR = 13;
   localparam int ISF_ST_WT = 12;
   localparam int ISF_ST_TR = 9;
   localparam int ISF_ST_AC = 8;
   // Reset values
   localparam logic [15:0] ISF_STAT_RST = 16'h0000;
   localparam logic [15:0] ISF_CTRL_RST = 16'h0000;
   localparam logic [7:0] ISF_DATA_RST = 8'h00;
   // Serial clock falling-edge counts within one byte
   localparam logic [3:0] ISF_CNT_ZERO = 4'h0;
   localparam logic [3:0] ISF_CNT_BIT8 = 4'h7;
   localparam logic [3:0] ISF_CNT_BIT9 = 4'h8;
   // Synchroniser depth on pins
   localparam int ISF_SYNC_STAGES = 2;
endpackage

/* rtl/isf_line_if.sv */
`timescale 1ns/100ps
interface isf_line_if;
   logic scl;
   logic sda;
   logic scl_fall;
   logic scl_rise;
   logic start_det;
   logic stop_det;
   modport src (output scl, output sda, output scl_fall, output scl_rise,
      output start_det, output stop_det);
   modport snk (input scl, input sda, input scl_fall, input scl_rise,
      input start_det, input stop_det);
endinterface

/* rtl/isf_pin_sync.sv */
`timescale 1ns/100ps
module isf_pin_sync
   import isf_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic scl_in,
   input wire logic sda_in,
   isf_line_if.src line
);
   import isf_pkg::*;

   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic scl_d_r;
   logic sda_d_r;

   // First stage is read only by the second stage
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_sync_r <= 2'h3;
         sda_sync_r <= 2'h3;
      end else if (ce_in) begin
         scl_sync_r <= {scl_sync_r[0], scl_in};
         sda_sync_r <= {sda_sync_r[0], sda_in};
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_d_r <= 1'h1;
         sda_d_r <= 1'h1;
      end else if (ce_in) begin
         scl_d_r <= scl_sync_r[1];
         sda_d_r <= sda_sync_r[1];
      end
   end

   assign line.scl = scl_sync_r[1];
   assign line.sda = sda_sync_r[1];
   assign line.scl_fall = scl_d_r & ~scl_sync_r[1];
   assign line.scl_rise = ~scl_d_r & scl_sync_r[1];
   // Data edges while the clock is high mark start and stop
   assign line.start_det = scl_d_r & scl_sync_r[1] & sda_d_r & ~sda_sync_r[1];
   assign line.stop_det = scl_d_r & scl_sync_r[1] & ~sda_d_r & sda_sync_r[1];
endmodule

/* rtl/isf_flags.sv */
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/100ps
module isf_flags
   import isf_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_b_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_b_out
);
   import isf_pkg::*;

   isf_line_if line ();

   isf_pin_sync u_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .line(line)
   );

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] ctrl_r;
   logic [7:0] data_r;
   logic [31:0] rdata_r;
   logic rdy_r;
   logic slverr_r;
   logic acc;
   logic hit;
   logic wr_ctrl, wr_data, wr_trig, rd_data;
   logic lret_w, wret_w, stt_w, spt_w;

   assign hit = paddr_in == ISF_OFF_CTRL || paddr_in == ISF_OFF_DATA ||
      paddr_in == ISF_OFF_TRIG || paddr_in == ISF_OFF_STAT;
   assign acc = ce_in & psel_in & penable_in & rdy_r;
   assign wr_ctrl = acc & pwrite_in & paddr_in == ISF_OFF_CTRL;
   assign wr_data = acc & pwrite_in & paddr_in == ISF_OFF_DATA;
   assign wr_trig = acc & pwrite_in & paddr_in == ISF_OFF_TRIG;
   assign rd_data = acc & ~pwrite_in & paddr_in == ISF_OFF_DATA;
   assign lret_w = wr_trig & pwdata_in[ISF_TRG_LRET];
   assign wret_w = wr_trig & pwdata_in[ISF_TRG_WRET];
   assign stt_w = wr_trig & pwdata_in[ISF_TRG_STT];
   assign spt_w = wr_trig & pwdata_in[ISF_TRG_SPT];

   logic en, slwt, cont;
   logic [6:0] own_addr;
   assign en = ctrl_r[ISF_CTL_EN];
   assign slwt = ctrl_r[ISF_CTL_SLWT];
   assign cont = ctrl_r[ISF_CTL_CONT];
   assign own_addr = ctrl_r[ISF_CTL_ADDR_LSB +: 7];

   // One wait state so read data comes from a flop
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdy_r <= 1'h0;
      end else if (ce_in) begin
         rdy_r <= psel_in & penable_in & ~rdy_r;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_r <= ISF_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= pwdata_in[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [3:0] cnt_r;
   logic addr_ph_r, master_r, xmit_r, match_r, ack_r, rel_r, lead_r;
   logic stt_req_r, spt_req_r, dat_wr_r;
   logic [7:0] rx_sh_r;
   logic wait_r, wait9_r, pend_r, held_r;
   logic [15:0] stat;
   logic en_d_r;
   logic reinit;
   logic fall8, fall9, fall_sel, first_fall, nack_ev, al_ev, part;

   assign reinit = en != en_d_r;
   assign fall8 = line.scl_fall & cnt_r == ISF_CNT_BIT8;
   assign fall9 = line.scl_fall & cnt_r == ISF_CNT_BIT9;
   assign fall_sel = slwt ? fall9 : fall8;
   assign first_fall = line.scl_fall & lead_r;
   assign part = master_r | match_r;
   assign nack_ev = line.scl_rise & cnt_r == ISF_CNT_BIT9 & line.sda & part;
   // Own high bit overdriven low means another master won
   assign al_ev = master_r & xmit_r & line.scl_rise & cnt_r < ISF_CNT_BIT9 &
      data_r[3'(ISF_CNT_BIT8 - cnt_r)] & ~line.sda;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         en_d_r <= 1'h0;
      end else if (ce_in) begin
         en_d_r <= en;
      end
   end

   // Bit counter and address phase
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_r <= ISF_CNT_ZERO;
         addr_ph_r <= 1'h0;
         lead_r <= 1'h0;
      end else if (ce_in) begin
         if (!en || line.start_det || line.stop_det) begin
            cnt_r <= ISF_CNT_ZERO;
            addr_ph_r <= en & line.start_det;
            lead_r <= en & line.start_det;
         end else if (fall9) begin
            cnt_r <= ISF_CNT_ZERO;
            addr_ph_r <= 1'h0;
         end else if (first_fall) begin
            // Start's own clock fall opens the byte but carries no bit
            lead_r <= 1'h0;
         end else if (line.scl_fall) begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_sh_r <= ISF_DATA_RST;
         ack_r <= 1'h0;
      end else if (ce_in) begin
         if (line.scl_rise && cnt_r < ISF_CNT_BIT9) begin
            rx_sh_r <= {rx_sh_r[6:0], line.sda};
         end
         if (lret_w || reinit) begin
            ack_r <= 1'h0;
         end else if (line.scl_rise && cnt_r == ISF_CNT_BIT9) begin
            ack_r <= ~line.sda;
         end
      end
   end

   // Start and stop requests stay pending until the bus acts on them
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stt_req_r <= 1'h0;
         spt_req_r <= 1'h0;
         dat_wr_r <= 1'h0;
      end else if (ce_in) begin
         stt_req_r <= en & (stt_w | (stt_req_r & ~line.start_det));
         spt_req_r <= en & (spt_w | (spt_req_r & ~line.stop_det));
         dat_wr_r <= en & ~line.start_det & (wr_data | dat_wr_r);
      end
   end

   // Role and direction
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         master_r <= 1'h0;
         xmit_r <= 1'h0;
         match_r <= 1'h0;
         rel_r <= 1'h0;
      end else if (ce_in) begin
         if (reinit || lret_w || line.stop_det) begin
            master_r <= 1'h0;
            xmit_r <= 1'h0;
            match_r <= 1'h0;
            rel_r <= 1'h0;
         end else if (al_ev) begin
            master_r <= 1'h0;
            xmit_r <= 1'h0;
         end else if (line.start_det) begin
            master_r <= stt_req_r;
            xmit_r <= stt_req_r;
            match_r <= 1'h0;
            rel_r <= 1'h0;
         end else if (wret_w && wait_r && wait9_r) begin
            xmit_r <= 1'h0;
            rel_r <= 1'h1;
         end else if (fall8 && addr_ph_r) begin
            if (master_r) begin
               xmit_r <= ~rx_sh_r[0];
            end else if (rx_sh_r[7:1] == own_addr) begin
               match_r <= 1'h1;
               xmit_r <= rx_sh_r[0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wait flag: strong clears, then sets, then weak clears
   logic w_set, w_set9, w_hclr, w_lclr, wait_nxt;

   always_comb begin
      w_set9 = 1'h0;
      w_set = 1'h0;
      if (part && !addr_ph_r && fall_sel) begin
         w_set = 1'h1;
         w_set9 = slwt;
      end
      if (master_r && first_fall && !dat_wr_r) begin
         w_set = 1'h1;
      end
      if (addr_ph_r && fall9 && (master_r || (match_r && !xmit_r))) begin
         w_set = 1'h1;
         w_set9 = 1'h1;
      end
      if (addr_ph_r && nack_ev && master_r && !stt_req_r && !spt_req_r) begin
         w_set = 1'h1;
      end
      if (addr_ph_r && nack_ev && match_r) begin
         w_set = 1'h1;
      end
   end

   assign w_hclr = lret_w | (spt_w & master_r & cont) |
      (wr_data & xmit_r & cont) |
      (rd_data & ~xmit_r & cont & wait_r & ~wait9_r) |
      (rd_data & ~xmit_r & cont & wait_r & wait9_r & ack_r);
   assign w_lclr = wret_w |
      ((stt_w | spt_w) & master_r & ~cont) |
      (wr_data & ~xmit_r & ~cont);
   assign wait_nxt = w_hclr ? 1'h0 : w_set ? 1'h1 : w_lclr ? 1'h0 : wait_r;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wait_r <= ISF_STAT_RST[ISF_ST_WT];
         wait9_r <= 1'h0;
      end else if (ce_in) begin
         if (reinit) begin
            wait_r <= ISF_STAT_RST[ISF_ST_WT];
            wait9_r <= 1'h0;
         end else begin
            wait_r <= wait_nxt;
            if (w_set && !w_hclr) begin
               wait9_r <= w_set9;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending flag and the data register
   logic p_set, p_hclr, p_lclr;
   logic rx_done;

   assign rx_done = part & ~xmit_r & ~addr_ph_r & fall_sel;
   assign p_hclr = lret_w | al_ev |
      (master_r & addr_ph_r & fall9) |
      (xmit_r & ~addr_ph_r & fall_sel);
   assign p_set = (wr_data & part & ~wait_r & ~(master_r & addr_ph_r)) |
      rx_done | (~master_r & match_r & addr_ph_r & fall9);
   assign p_lclr = rd_data & ~held_r;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pend_r <= ISF_STAT_RST[ISF_ST_DR];
      end else if (ce_in) begin
         if (reinit) begin
            pend_r <= ISF_STAT_RST[ISF_ST_DR];
         end else if (p_hclr) begin
            pend_r <= 1'h0;
         end else if (p_set) begin
            pend_r <= 1'h1;
         end else if (p_lclr) begin
            pend_r <= 1'h0;
         end
      end
   end

   // Byte arriving while the last one is unread waits in the shifter
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         data_r <= ISF_DATA_RST;
         held_r <= 1'h0;
      end else if (ce_in) begin
         if (reinit) begin
            held_r <= 1'h0;
         end else if (wr_data) begin
            data_r <= pwdata_in[7:0];
         end else if (rx_done && pend_r) begin
            held_r <= 1'h1;
         end else if (rx_done) begin
            data_r <= rx_sh_r;
         end else if (rd_data && held_r) begin
            data_r <= rx_sh_r;
            held_r <= 1'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      stat = ISF_STAT_RST;
      stat[ISF_ST_MS] = master_r;
      stat[ISF_ST_DR] = pend_r;
      stat[ISF_ST_WT] = wait_r;
      stat[ISF_ST_TR] = xmit_r;
      stat[ISF_ST_AC] = ack_r;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_r <= 32'h0000_0000;
         slverr_r <= 1'h0;
      end else if (ce_in && psel_in && penable_in && !rdy_r) begin
         slverr_r <= ~hit;
         case (paddr_in)
            ISF_OFF_CTRL: rdata_r <= {16'h0000, ctrl_r};
            ISF_OFF_DATA: rdata_r <= {24'h00_0000, data_r};
            ISF_OFF_STAT: rdata_r <= {16'h0000, stat};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata_out = rdata_r;
   assign pready_out = rdy_r;
   assign pslverr_out = rdy_r & slverr_r;

   // Pins only ever pull low
   logic sda_drv;
   assign sda_drv = en & ~rel_r & ((xmit_r & cnt_r < ISF_CNT_BIT9 &
      ~data_r[3'(ISF_CNT_BIT8 - cnt_r)]) |
      (part & ~xmit_r & cnt_r == ISF_CNT_BIT9));
   assign scl_out = 1'h0;
   assign sda_out = 1'h0;
   assign scl_oe_b_out = ~(en & wait_r & ~rel_r);
   assign sda_oe_b_out = ~sda_drv;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence s_leave;
      ce_in && lret_w;
   endsequence
   sequence s_cleared;
      !pend_r && !wait_r;
   endsequence

   property p_leave_clears;
      s_leave |=> s_cleared;
   endproperty
   a_leave_clears: assert property (p_leave_clears)
      else $error("leave trigger did not clear flags");

   property p_al_clears;
      ce_in && al_ev |=> !pend_r && !master_r;
   endproperty
   a_al_clears: assert property (p_al_clears)
      else $error("arbitration loss did not clear pending");

   property p_master_addr9;
      ce_in && !reinit && master_r && addr_ph_r && fall9 && !w_hclr
         |=> !pend_r && wait_r;
   endproperty
   a_master_addr9: assert property (p_master_addr9)
      else $error("master address ninth edge flags wrong");

   property p_set_beats_wret;
      ce_in && !reinit && w_set && wret_w && !w_hclr |=> wait_r;
   endproperty
   a_set_beats_wret: assert property (p_set_beats_wret)
      else $error("wait release beat a set");

   property p_cont_write;
      ce_in && wr_data && xmit_r && cont |=> !wait_r;
   endproperty
   a_cont_write: assert property (p_cont_write)
      else $error("continuous write kept wait");

   property p_read_clear;
      ce_in && !reinit && rd_data && !held_r && !p_set && !p_hclr
         |=> !pend_r;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("read did not clear pending");

   property p_stretch;
      en && wait_r && !rel_r |-> !scl_oe_b_out;
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("clock not stretched in wait");

   property p_release9;
      ce_in && !reinit && !lret_w && !line.stop_det && !line.start_det &&
         wret_w && wait_r && wait9_r
         |=> !xmit_r && sda_oe_b_out && scl_oe_b_out;
   endproperty
   a_release9: assert property (p_release9)
      else $error("lines not released after wait release");

   property p_reinit;
      ce_in && reinit |=> !pend_r && !wait_r;
   endproperty
   a_reinit: assert property (p_reinit)
      else $error("enable change did not clear status");

   property p_rx_pend;
      ce_in && !reinit && rx_done && !p_hclr |=> pend_r;
   endproperty
   a_rx_pend: assert property (p_rx_pend)
      else $error("receive edge did not set pending");

   property p_apb_ready;
      ce_in && psel_in && penable_in && !rdy_r |=> pready_out;
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("bus answer late");
endmodule

/* bench/isf_i2c_master.sv */
`timescale 1ns/100ps
module isf_i2c_master (
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   localparam int HALF = 40;
   // Released lines float high through the bus pull-ups
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic start_cond();
      sda_out = 1'b0;
      #HALF;
      scl_out = 1'b0;
      #HALF;
   endtask
   task automatic stop_cond();
      #(HALF / 4);
      sda_out = 1'b0;
      #HALF;
      scl_out = 1'b1;
      wait (scl_in === 1'b1);
      #HALF;
      sda_out = 1'b1;
      #HALF;
   endtask
   // Data moves well after the clock fall, so no false start or stop
   task automatic clk_bit(input logic b, output logic s);
      #(HALF / 4);
      sda_out = b;
      #(HALF * 3 / 4);
      scl_out = 1'b1;
      // Stretching by the device holds us here
      wait (scl_in === 1'b1);
      s = sda_in;
      #HALF;
      scl_out = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack_b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
      end
      clk_bit(1'b1, ack_b);
   endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/100ps
module tb;
   import isf_pkg::*;
   logic clk_in, rst_b_in, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, dat;
   logic [31:0] pwdata, prdata, rd;
   logic scl_oe_b, sda_oe_b, scl_o, sda_o, m_scl, m_sda, ack_b;
   logic [6:0] own;
   int miscompares, n_tests, seed;
   wire scl_w = m_scl & (scl_oe_b ? 1'b1 : scl_o);
   wire sda_w = m_sda & (sda_oe_b ? 1'b1 : sda_o);
   isf_flags i_isf_flags (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .ce_in(1'b1), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .scl_in(scl_w), .scl_out(scl_o), .scl_oe_b_out(scl_oe_b),
      .sda_in(sda_w), .sda_out(sda_o), .sda_oe_b_out(sda_oe_b));
   isf_i2c_master i_isf_i2c_master (.scl_in(scl_w), .sda_in(sda_w),
      .scl_out(m_scl), .sda_out(m_sda));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("Counts: tests=%0d miscompares=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Slave answer time is not assumed, only bounded
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rv, output logic e);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_in);
      penable <= 1'b1;
      // Request stands until pready is seen high at a rising edge
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, d, x, e);
   endtask
   task automatic stat_bit(input int pos, input logic e);
      logic er;
      apb(1'b0, ISF_OFF_STAT, 32'h0, rd, er);
      chk(32'(rd[pos]), 32'(e));
   endtask
   task automatic wait_wt();
      logic er;
      int n;
      n = 0;
      do begin
         apb(1'b0, ISF_OFF_STAT, 32'h0, rd, er);
         n++;
      end while (rd[ISF_ST_WT] !== 1'b1 && n < 400);
      chk(32'(rd[ISF_ST_WT]), 32'h1);
   endtask
   function automatic logic [31:0] ctrl_word(input logic slwt,
      input logic [6:0] a);
      logic [31:0] w;
      w = 32'h0;
      w[ISF_CTL_EN] = 1'b1;
      w[ISF_CTL_SLWT] = slwt;
      w[ISF_CTL_ADDR_LSB +: 7] = a;
      return w;
   endfunction
   function automatic logic [7:0] addr_byte(input logic [6:0] a);
      return {a, 1'b0};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
   initial begin
      logic e;
      rst_b_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      seed = $urandom(32'hEFC3);
      repeat (6) @(posedge clk_in);
      rst_b_in <= 1'b1;
      apb(1'b0, ISF_OFF_STAT, 32'h0, rd, e);
      chk(rd, 32'h0);
      apb(1'b0, 8'h0C, 32'h0, rd, e);
      chk(32'(e), 32'h1);
      chk(rd, 32'h0);
      $display("Test reset and unmapped done");
      for (int s = 0; s < 2; s++) begin
         own = 7'($urandom);
         dat = 8'($urandom);
         wr(ISF_OFF_CTRL, ctrl_word(1'(s), own));
         // Foreign address: no acknowledge, no stretch
         i_isf_i2c_master.start_cond();
         i_isf_i2c_master.send_byte(addr_byte(own ^ 7'h01), ack_b);
         chk(32'(ack_b), 32'h1);
         stat_bit(ISF_ST_WT, 1'b0);
         i_isf_i2c_master.stop_cond();
         i_isf_i2c_master.start_cond();
         fork
            i_isf_i2c_master.send_byte(addr_byte(own), ack_b);
            begin
               wait_wt();
               chk(32'(scl_oe_b), 32'h0);
               // Empty the data register so the next byte is not held back
               apb(1'b0, ISF_OFF_DATA, 32'h0, rd, e);
               stat_bit(ISF_ST_DR, 1'b0);
               wr(ISF_OFF_DATA, 32'h0);
               stat_bit(ISF_ST_WT, 1'b0);
               chk(32'(scl_oe_b), 32'h1);
            end
         join
         chk(32'(ack_b), 32'h0);
         fork
            i_isf_i2c_master.send_byte(dat, ack_b);
            begin
               wait_wt();
               stat_bit(ISF_ST_DR, 1'b1);
               apb(1'b0, ISF_OFF_DATA, 32'h0, rd, e);
               chk(rd, {24'h0, dat});
               stat_bit(ISF_ST_DR, 1'b0);
               wr(ISF_OFF_TRIG, 32'h1 << ISF_TRG_WRET);
               stat_bit(ISF_ST_WT, 1'b0);
               stat_bit(ISF_ST_TR, 1'b0);
               chk(32'(scl_oe_b), 32'h1);
            end
         join
         i_isf_i2c_master.stop_cond();
         // Leave while both flags stand after an address match
         i_isf_i2c_master.start_cond();
         fork
            i_isf_i2c_master.send_byte(addr_byte(own), ack_b);
            begin
               wait_wt();
               stat_bit(ISF_ST_DR, 1'b1);
               wr(ISF_OFF_TRIG, 32'h1 << ISF_TRG_LRET);
               stat_bit(ISF_ST_WT, 1'b0);
               stat_bit(ISF_ST_DR, 1'b0);
               chk(32'(scl_oe_b), 32'h1);
            end
         join
         i_isf_i2c_master.stop_cond();
         // Start request before the bus start makes us master
         wr(ISF_OFF_TRIG, 32'h1 << ISF_TRG_STT);
         i_isf_i2c_master.start_cond();
         fork
            i_isf_i2c_master.send_byte(addr_byte(own), ack_b);
            begin
               wait_wt();
               stat_bit(ISF_ST_MS, 1'b1);
               wr(ISF_OFF_DATA, {24'h0, addr_byte(own)});
               stat_bit(ISF_ST_DR, 1'b0);
               wr(ISF_OFF_TRIG, 32'h1 << ISF_TRG_WRET);
               stat_bit(ISF_ST_WT, 1'b0);
               wait_wt();
               stat_bit(ISF_ST_DR, 1'b0);
               wr(ISF_OFF_TRIG, 32'h1 << ISF_TRG_SPT);
               stat_bit(ISF_ST_WT, 1'b0);
               wr(ISF_OFF_TRIG, 32'h1 << ISF_TRG_LRET);
               stat_bit(ISF_ST_MS, 1'b0);
            end
         join
         chk(32'(ack_b), 32'h1);
         i_isf_i2c_master.stop_cond();
         wr(ISF_OFF_CTRL, 32'h0);
         apb(1'b0, ISF_OFF_STAT, 32'h0, rd, e);
         chk(rd, 32'h0);
         $display("Test slave pass %0d done", s);
      end
      give_verdict();
   end
endmodule
